/* hdl/isa_decode_cfg.svh */
// Offsets, field positions, reset values and fixed addresses of the host port decoder.
`ifndef ISA_DECODE_CFG_SVH
`define ISA_DECODE_CFG_SVH

// Register byte offsets on the Wishbone slave.
`define REG_CTRL_OFS 4'h0
`define REG_STATUS_OFS 4'h4
`define REG_HITS_OFS 4'h8

// Control register fields and reset value.
`define CTRL_IRQ_EN_BIT 0
`define CTRL_DMA_EN_BIT 1
`define CTRL_DEC_EN_BIT 2
`define CTRL_RESET 3'h7

// Status register fields above the switch image.
`define STAT_IRQ_BIT 16
`define STAT_DRQ_BIT 17

// Factory switch image: contiguous mode, primary personality, base 2b8, spread 2e1,
// DMA channel 1, interrupt line 7.
`define SWITCH_RESET 16'h2b8f

// Spread footprint: low ten address bits that every decoded port carries.
`define SPREAD_LOW_ADDR 10'h2e1

// Selector codes for the DMA channel and interrupt line.
`define DMA_NONE 2'h0
`define IRQ_FIRST 3'h2
`define IRQ_LAST 3'h7

`endif

/* hdl/isa_decode_pkg.sv */
// Types shared by the host port decoder.
package isa_decode_pkg;

   // Host bus pins seen by the card.
   typedef struct packed {
      logic [15:0] addr;
      logic aen;
      logic ior_n;
      logic iow_n;
   } isa_pins_t;

   // Static switch and jumper image.
   typedef struct packed {
      logic spread_mode;
      logic alt_personality;
      logic [6:0] base_sw;
      logic [1:0] spread_sel;
      logic [1:0] dma_sel;
      logic [2:0] irq_sel;
   } sw_t;

   // Compatibility mode of the footprint.
   typedef enum logic {
      MODE_CONTIG,
      MODE_SPREAD
   } mode_t;

endpackage : isa_decode_pkg

/* hdl/isa_address_decode_config.sv */
// Host I/O decode, interrupt and DMA routing, and Wishbone status port of the card.
//
// Operation
// - One mode switch picks footprint and sharing.
// - Contiguous mode compares A3..A9 with switches.
// - Contiguous base: multiple of eight, 100..3f8.
// - Contiguous mode answers eight consecutive ports.
// - Spread base from two switches: 2e1..62e1.
// - Spread mode decodes sixteen scattered upper ports.
// - Interrupt shareable only in spread mode.
// - Personality switch; primary one is default.
// - DMA routed to channel 1, 2, 3 or none.
// - Interrupt on line 2..7 or none.
// - Factory defaults 2b8, 2e1, DMA 1, IRQ 7.
// - Switch one side gives address bit one.
// - DMA request and acknowledge share one channel.
`timescale 1ns/10ps
`include "isa_decode_cfg.svh"

module isa_address_decode_config
   import isa_decode_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Host bus pins.
   input wire isa_pins_t isa,
   input wire logic [3:1] dma_ack_line_n,
   output logic [3:1] dma_req_line,
   output logic [7:2] irq_line_out,
   output logic [7:2] irq_line_oe,
   // Static switches and jumpers.
   input wire sw_t config_switch_block,
   // Controller core side.
   input wire logic core_irq,
   input wire logic core_dma_req,
   output logic card_sel,
   output logic io_rd,
   output logic io_wr,
   output logic [3:0] reg_index,
   output logic alt_personality,
   output logic dma_ack
);

   // Synchroniser stages for pins and switches.
   isa_pins_t isa_s1_r;
   isa_pins_t isa_s2_r;
   logic [3:1] dack_s1_r;
   logic [3:1] dack_s2_r;
   sw_t sw_s1_r;
   sw_t sw_r;

   // Software state.
   logic [2:0] ctrl_r;
   logic [15:0] hits_r;
   logic [15:0] hits_nxt;
   logic sel_d_r;

   // Decode wires.
   mode_t mode;
   logic io_cycle;
   logic contig_hit;
   logic spread_hit;
   logic addr_hit;
   logic sel_now;
   logic [3:0] index_now;
   logic [9:3] contig_base;
   logic [3:1] dma_chan_onehot;
   logic [7:2] irq_line_onehot;
   logic irq_active;
   logic drq_active;
   logic dack_now;
   logic rd_now;
   logic wr_now;
   logic [3:0] index_nxt;
   logic [3:1] dma_req_nxt;
   logic [7:2] irq_out_nxt;
   logic [7:2] irq_oe_nxt;
   logic dma_ack_nxt;

   // Wishbone wires.
   logic wb_req;
   logic wb_wr;
   logic hit_ctrl;
   logic hit_status;
   logic hit_hits;
   logic [31:0] rd_data;
   logic [31:0] dat_nxt;

   // Pins arrive from the host bus clock, so two flops come first; the switch image goes
   // through a like pair of its own so that a switch flipped on a live card cannot go metastable.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         isa_s1_r <= '{addr: 16'h0000, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1};
         isa_s2_r <= '{addr: 16'h0000, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1};
         dack_s1_r <= 3'h7;
         dack_s2_r <= 3'h7;
      end else begin
         isa_s1_r <= isa;
         isa_s2_r <= isa_s1_r;
         dack_s1_r <= dma_ack_line_n;
         dack_s2_r <= dack_s1_r;
      end
   end

   // Switch image resets to the factory settings until the first samples land.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sw_s1_r <= sw_t'(`SWITCH_RESET);
         sw_r <= sw_t'(`SWITCH_RESET);
      end else begin
         sw_s1_r <= config_switch_block;
         sw_r <= sw_s1_r;
      end
   end

   // The single mode switch chooses the footprint and the interrupt style.
   assign mode = sw_r.spread_mode ? MODE_SPREAD : MODE_CONTIG;

   // Only processor I/O strobes count; AEN high marks a DMA cycle on the bus.
   assign io_cycle = !isa_s2_r.aen && (!isa_s2_r.ior_n || !isa_s2_r.iow_n);

   // Each switch that is set to one yields a one on its address bit.
   assign contig_base = sw_r.base_sw;

   // Contiguous block: A9..A3 against the switches, A2..A0 pick one of eight ports.
   // Only the low ten lines are decoded, so the block repeats through upper space.
   assign contig_hit = (isa_s2_r.addr[9:3] == contig_base);

   // Spread footprint: fixed low ten bits, A14..A13 from the two base switches,
   // and A15 with A12..A10 choosing one of sixteen ports.
   assign spread_hit = (isa_s2_r.addr[9:0] == `SPREAD_LOW_ADDR)
      && (isa_s2_r.addr[14:13] == sw_r.spread_sel);

   // Footprint selection by mode.
   assign addr_hit = (mode == MODE_SPREAD) ? spread_hit : contig_hit;
   assign sel_now = io_cycle && addr_hit && ctrl_r[`CTRL_DEC_EN_BIT];
   assign index_now = (mode == MODE_SPREAD)
      ? {isa_s2_r.addr[15], isa_s2_r.addr[12:10]}
      : {1'b0, isa_s2_r.addr[2:0]};

   // Per-strobe qualifiers and an index that stands only while the card is selected,
   // so the core never acts on a stale index between host cycles.
   assign rd_now = sel_now && !isa_s2_r.ior_n;
   assign wr_now = sel_now && !isa_s2_r.iow_n;
   assign index_nxt = sel_now ? index_now : 4'h0;

   // Card select and strobes toward the controller core.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         card_sel <= 1'b0;
         io_rd <= 1'b0;
         io_wr <= 1'b0;
      end else begin
         card_sel <= sel_now;
         io_rd <= rd_now;
         io_wr <= wr_now;
      end
   end

   // Register index toward the core.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_index <= 4'h0;
      end else begin
         reg_index <= index_nxt;
      end
   end

   // Personality switch; the reset image holds the primary one.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         alt_personality <= 1'b0;
      end else begin
         alt_personality <= sw_r.alt_personality;
      end
   end

   // Request is gated by software so the DMA path can be parked without moving a jumper.
   assign drq_active = core_dma_req && ctrl_r[`CTRL_DMA_EN_BIT];

   // One selector drives both the request and the acknowledge of the same channel.
   genvar ch;
   generate
      for (ch = 1; ch <= 3; ch++) begin : g_dma
         assign dma_chan_onehot[ch] = (sw_r.dma_sel == 2'(ch));
         assign dma_req_nxt[ch] = drq_active && dma_chan_onehot[ch];
      end
   endgenerate

   // Request lines in one register, so each output has a single driving process.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dma_req_line <= 3'h0;
      end else begin
         dma_req_line <= dma_req_nxt;
      end
   end

   // Acknowledge is taken only from the channel whose request is routed.
   assign dack_now = |(dma_chan_onehot & ~dack_s2_r) && ctrl_r[`CTRL_DMA_EN_BIT];

   // Acknowledge toward the core; a selector of none never acknowledges.
   assign dma_ack_nxt = dack_now && (sw_r.dma_sel != `DMA_NONE);

   // Registered, so the core sees a clean level three edges after the pin moves.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dma_ack <= 1'b0;
      end else begin
         dma_ack <= dma_ack_nxt;
      end
   end

   // Interrupt request after the software enable.
   assign irq_active = core_irq && ctrl_r[`CTRL_IRQ_EN_BIT];

   // Per line: contiguous mode drives the chosen line at all times, so no other card
   // may share it; spread mode drives only while asserting and releases otherwise.
   genvar ln;
   generate
      for (ln = 2; ln <= 7; ln++) begin : g_irq
         assign irq_line_onehot[ln] = (sw_r.irq_sel == 3'(ln))
            && (sw_r.irq_sel >= `IRQ_FIRST) && (sw_r.irq_sel <= `IRQ_LAST);
         assign irq_out_nxt[ln] = irq_line_onehot[ln] && irq_active;
         assign irq_oe_nxt[ln] = irq_line_onehot[ln]
            && ((mode == MODE_CONTIG) || irq_active);
      end
   endgenerate

   // Interrupt line values.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_line_out <= 6'h0;
      end else begin
         irq_line_out <= irq_out_nxt;
      end
   end

   // Drive enables; letting go of an idle line in spread mode is what allows sharing.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_line_oe <= 6'h0;
      end else begin
         irq_line_oe <= irq_oe_nxt;
      end
   end

   // Wishbone decode; the slave answers every address in one cycle, unmapped ones read zero.
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr = wb_req && wb_we_i;
   assign hit_ctrl = (wb_adr_i == `REG_CTRL_OFS);
   assign hit_status = (wb_adr_i == `REG_STATUS_OFS);
   assign hit_hits = (wb_adr_i == `REG_HITS_OFS);
   assign rd_data = hit_ctrl ? {29'h0, ctrl_r}
      : hit_status ? {14'h0, drq_active, irq_active, sw_r}
      : hit_hits ? {16'h0, hits_r}
      : 32'h0;

   // Select counter; a new select in the clearing cycle wins and counts as one.
   assign hits_nxt = (wb_wr && hit_hits && wb_sel_i[0])
      ? {15'h0, sel_now && !sel_d_r}
      : hits_r + {15'h0, sel_now && !sel_d_r};

   // Read data stands only in the ack cycle; zero otherwise keeps a shared bus mux simple.
   assign dat_nxt = wb_req ? rd_data : 32'h0;

   // Bus answer and data.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= dat_nxt;
      end
   end

   // Software registers; only the lowest byte lane carries control bits.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= `CTRL_RESET;
         hits_r <= 16'h0;
         sel_d_r <= 1'b0;
      end else begin
         if (wb_wr && hit_ctrl && wb_sel_i[0]) begin
            ctrl_r <= wb_dat_i[2:0];
         end
         hits_r <= hits_nxt;
         sel_d_r <= sel_now;
      end
   end

endmodule : isa_address_decode_config

/* bench/isa_host_model.sv */
// Host bus model that runs processor I/O cycles and DMA acknowledges.
`timescale 1ns/10ps
module isa_host_model
   import isa_decode_pkg::*;
(
   // Clock.
   input wire logic clk,
   // Pins towards the card.
   output isa_pins_t isa,
   output logic [3:1] dma_ack_line_n
);
   // Idle bus: both strobes high, no acknowledge asserted.
   initial begin
      isa = '{addr: 16'h0, aen: 1'b0, ior_n: 1'b1, iow_n: 1'b1};
      dma_ack_line_n = 3'h7;
   end
   // Callers give only bases at or above 100 and one card per base.
   task automatic io_on(input logic [15:0] a, input logic dma, input logic wr);
      isa <= '{addr: a, aen: dma, ior_n: wr, iow_n: !wr};
   endtask : io_on
   // A released address bus floats, so the last address is inverted, not kept.
   task automatic io_off();
      isa <= '{addr: ~isa.addr, aen: 1'b0, ior_n: 1'b1, iow_n: 1'b1};
   endtask : io_off
   task automatic dack(input logic [3:1] v);
      dma_ack_line_n <= v;
   endtask : dack
endmodule : isa_host_model

/* bench/isa_address_decode_config_asserts.sv */
// Checker of decode, routing and Wishbone answer timing.
`timescale 1ns/10ps
module isa_address_decode_config_asserts
   import isa_decode_pkg::*;
(
   // Clock, reset and Wishbone.
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Pins, switches and core requests.
   input wire isa_pins_t isa,
   input wire sw_t config_switch_block,
   input wire logic core_irq,
   input wire logic core_dma_req,
   // Decode and routing outputs.
   input wire logic [3:1] dma_req_line,
   input wire logic [7:2] irq_line_out,
   input wire logic [7:2] irq_line_oe,
   input wire logic card_sel,
   input wire logic [3:0] reg_index
);
   wire spread = config_switch_block.spread_mode;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // A taken request sees one ack pulse that drops at the next edge.
   sequence s_taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_pulse: assert property (s_taken |=> s_pulse)
      else $error("ack is not a single pulse");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");
   // Pins and switches both need three edges to reach the outputs.
   a_sel_io_cycle: assert property (card_sel |->
      $past(!isa.aen && !(isa.ior_n && isa.iow_n), 3)) else $error("select outside I/O cycle");
   a_contig_hit: assert property (card_sel && !$past(spread, 3) |->
      $past(isa.addr[9:3] == config_switch_block.base_sw, 3)
      && reg_index == {1'b0, $past(isa.addr[2:0], 3)}) else $error("contiguous decode wrong");
   a_spread_hit: assert property (card_sel && $past(spread, 3) |->
      $past(isa.addr[9:0] == 10'h2e1 && isa.addr[14:13] == config_switch_block.spread_sel, 3)
      && reg_index == $past({isa.addr[15], isa.addr[12:10]}, 3)) else $error("spread decode wrong");
   a_dma_route: assert property (|dma_req_line |->
      $onehot(dma_req_line) && $past(core_dma_req)) else $error("DMA request misrouted");
   a_irq_route: assert property (|irq_line_out |->
      $onehot(irq_line_out) && $past(core_irq) && (irq_line_out & ~irq_line_oe) == 6'h0)
      else $error("interrupt line misrouted");
   a_share_spread: assert property (spread && $past(spread, 4) && !$past(core_irq) |->
      irq_line_oe == 6'h0) else $error("shared line driven while idle");
endmodule : isa_address_decode_config_asserts
bind isa_address_decode_config isa_address_decode_config_asserts chk_u (.clk, .rst, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .isa, .config_switch_block, .core_irq, .core_dma_req, .dma_req_line,
   .irq_line_out, .irq_line_oe, .card_sel, .reg_index);

/* bench/isa_address_decode_config_bench.sv */
// Self-checking bench of the host port decoder.
`timescale 1ns/10ps
`include "isa_decode_cfg.svh"
module isa_address_decode_config_bench
   import isa_decode_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, core_irq = 1'b0, core_dma_req = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [3:0] wb_sel_i = 4'hf, wb_adr_i = 4'h0, reg_index;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic card_sel, io_rd, io_wr, alt_personality, dma_ack;
   logic [3:1] dma_req_line, dma_ack_line_n, e3;
   logic [7:2] irq_line_out, irq_line_oe, e6;
   logic [15:0] b;
   logic [6:0] bases [3] = '{7'h57, 7'h20, 7'h7f};
   isa_pins_t isa;
   sw_t sw = `SWITCH_RESET;
   int n_fail = 0, total_checks = 0, cycles = 0;
   isa_address_decode_config dut_u (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i,
      .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .isa, .dma_ack_line_n, .dma_req_line,
      .irq_line_out, .irq_line_oe, .config_switch_block(sw), .core_irq, .core_dma_req,
      .card_sel, .io_rd, .io_wr, .reg_index, .alt_personality, .dma_ack);
   isa_host_model host_u (.clk, .isa, .dma_ack_line_n);
   always #5 clk = ~clk;
   // A hang is cut short at 5000 cycles, well beyond the roughly five hundred cycles the run needs.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_fail = n_fail + 1;
         conclude();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   // Outputs are read mid-cycle, after the three-edge pin latency has passed.
   task automatic settle();
      repeat (5) @(posedge clk);
      @(negedge clk);
   endtask : settle
   // Single classic cycle; ack and read data are taken at the rising edge that shows ack.
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic io(input logic [15:0] a, input logic d, w, h, input logic [3:0] x);
      @(posedge clk);
      host_u.io_on(a, d, w);
      settle();
      check({card_sel, io_rd, io_wr, reg_index}, {h, h & !w, h & w, h ? x : 4'h0});
      @(posedge clk);
      host_u.io_off();
      settle();
   endtask : io
   // Main sequence: register map, both footprints, then DMA and interrupt routing.
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      wb(1'b0, `REG_STATUS_OFS, 32'h0);
      check(q[15:0], {2'h0, 7'h57, 2'h0, 2'h1, 3'h7});
      wb(1'b0, 4'hc, 32'h0);
      check(q, 32'h0);
      check(alt_personality, 1'b0);
      foreach (bases[k]) begin
         @(posedge clk);
         sw.base_sw <= bases[k];
         b = {6'h0, bases[k], 3'h0};
         io(b, 1'b0, 1'b1, 1'b1, 4'h0);
         io(b + 16'h7, 1'b0, 1'b0, 1'b1, 4'h7);
         io(b + 16'h8, 1'b0, 1'b1, 1'b0, 4'h0);
         io(b - 16'h1, 1'b0, 1'b0, 1'b0, 4'h0);
      end
      wb(1'b0, `REG_HITS_OFS, 32'h0);
      check(q, 32'h6);
      wb(1'b1, `REG_HITS_OFS, 32'h0);
      wb(1'b0, `REG_HITS_OFS, 32'h0);
      check(q, 32'h0);
      io(b, 1'b1, 1'b1, 1'b0, 4'h0);
      wb(1'b1, `REG_CTRL_OFS, 32'h3);
      wb(1'b0, `REG_CTRL_OFS, 32'h0);
      check(q, 32'h3);
      io(b, 1'b0, 1'b1, 1'b0, 4'h0);
      wb(1'b1, `REG_CTRL_OFS, 32'h7);
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         sw.spread_mode <= 1'b1;
         sw.spread_sel <= 2'(s);
         io({1'b0, 2'(s), 3'h0, 10'h2e1}, 1'b0, 1'b0, 1'b1, 4'h0);
         io({1'b1, 2'(s), 3'h3, 10'h2e1}, 1'b0, 1'b1, 1'b1, 4'hb);
         io({1'b0, 2'(s + 1), 3'h0, 10'h2e1}, 1'b0, 1'b1, 1'b0, 4'h0);
      end
      io(b, 1'b0, 1'b1, 1'b0, 4'h0);
      wb(1'b0, `REG_HITS_OFS, 32'h0);
      check(q, 32'h8);
      @(posedge clk);
      sw.spread_mode <= 1'b0;
      sw.alt_personality <= 1'b1;
      core_dma_req <= 1'b1;
      core_irq <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         @(posedge clk);
         sw.irq_sel <= 3'(c);
         sw.dma_sel <= 2'(c);
         e3 = 3'((4'h1 << (c % 4)) >> 1);
         e6 = 6'((8'h1 << c) >> 2);
         host_u.dack(~e3);
         settle();
         check(dma_req_line, e3);
         check(dma_ack, c % 4 != 0);
         check({irq_line_out, irq_line_oe}, {e6, e6});
         @(posedge clk);
         host_u.dack(e3);
         settle();
         check(dma_ack, 1'b0);
      end
      check(alt_personality, 1'b1);
      wb(1'b0, `REG_STATUS_OFS, 32'h0);
      check(q[17:0], {2'h3, 1'b0, 1'b1, 7'h7f, 2'h3, 2'h3, 3'h7});
      @(posedge clk);
      core_irq <= 1'b0;
      settle();
      check(irq_line_oe, 6'h20);
      @(posedge clk);
      sw.spread_mode <= 1'b1;
      settle();
      check(irq_line_oe, 6'h0);
      conclude();
   end
endmodule : isa_address_decode_config_bench
